// File: inc/xl_pkg.sv
package xl_pkg;
  localparam int LANES = 8;
  localparam int ADDR_W = 12;
  localparam int MODE_W = 5;
  localparam int TEST_W = 4;
  // register indices; the byte address is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h200;
  localparam logic [9:0] IDX_LINK_A = 10'h20A;
  localparam logic [9:0] IDX_LINK_B = 10'h20B;
  localparam logic [9:0] IDX_STAT_A = 10'h20C;
  localparam logic [9:0] IDX_STAT_B = 10'h20D;
  localparam logic [9:0] IDX_FAULT = 10'h20E;
  localparam logic [7:0] RST_EXTRA = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [1:0] RST_FAULT = 2'h0;
  localparam logic [31:0] RST_RDATA = 32'h0;
  localparam int SER_BIT = 0;
  localparam int LANE_LSB = 1;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PD_A_BIT = 1;
  localparam int CTRL_PD_B_BIT = 2;
  localparam int FAULT_A_BIT = 0;
  localparam int FAULT_B_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_ACK = 2'h2
  } bus_state_t;
endpackage

// File: rtl/byte_reg.sv
`timescale 1ns/100ps
module byte_reg #(
  parameter logic [7:0] RESET = 8'h00
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] value_q
);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      value_q <= RESET;
    end else if (we) begin
      value_q <= wdata;
    end
  end
endmodule

// File: rtl/lane_gate.sv
`timescale 1ns/100ps
module lane_gate #(
  parameter int LANES = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic link_on,
  input wire logic [LANES-1:0] mode_lanes,
  input wire logic [LANES-1:0] force_lanes,
  input wire logic ser_force,
  output logic [LANES-1:0] clk_en_q,
  output logic [LANES-1:0] ser_clk_q
);
  logic [LANES-1:0] clk_en_d;
  logic [LANES-1:0] ser_en;
  logic [LANES-1:0] lower_ok;
  logic [LANES-1:0] ser_clk_d;

  always_comb begin
    clk_en_d = link_on ? (mode_lanes | force_lanes) : '0; // R5 R11 R13
    ser_en = link_on ? (mode_lanes | (ser_force ? force_lanes : '0)) : '0; // R6 R7 R8
    lower_ok[0] = 1'b1;
    for (int n = 1; n < LANES; n++) begin
      lower_ok[n] = lower_ok[n-1] & clk_en_d[n-1]; // R12
    end
    ser_clk_d = ser_en & lower_ok; // R12
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clk_en_q <= '0;
      ser_clk_q <= '0;
    end else begin
      clk_en_q <= clk_en_d;
      ser_clk_q <= ser_clk_d;
    end
  end

  logic [LANES-1:0] chain_ok;
  always_comb begin
    chain_ok[0] = 1'b1;
    for (int n = 1; n < LANES; n++) begin
      chain_ok[n] = chain_ok[n-1] & clk_en_q[n-1];
    end
  end

  force_clk_a: assert property (@(posedge clk) disable iff (!nrst) // R5
    link_on |=> (clk_en_q & $past(force_lanes)) == $past(force_lanes))
    else $error("forced lane clock not enabled");
  ser_off_a: assert property (@(posedge clk) disable iff (!nrst) // R7
    !ser_force |=> (ser_clk_q & ~$past(mode_lanes)) == '0)
    else $error("forced serializer on without serializer bit");
  pd_gate_a: assert property (@(posedge clk) disable iff (!nrst) // R11
    !link_on |=> clk_en_q == '0 && ser_clk_q == '0)
    else $error("lane active while link off");
  ser_chain_a: assert property (@(posedge clk) disable iff (!nrst) // R12
    (ser_clk_q & ~chain_ok) == '0)
    else $error("serializer clocked without lower lanes");
  ser_on_a: assert property (@(posedge clk) disable iff (!nrst) // R8
    link_on && ser_force && force_lanes[1] && clk_en_d[0] |=> ser_clk_q[1])
    else $error("forced serializer 1 not enabled");
endmodule

// File: rtl/extra_lane_ctrl.sv
`timescale 1ns/100ps
// Notes on behaviour
// R1 - link A register at 0x20A, resets 0x00
// R2 - link B register at 0x20B, resets 0x00
// R3 - link A bits 7..1 force lanes 1..7
// R4 - link B bits 7..1 force lanes 1..7
// R5 - forced lane on despite unused by mode
// R6 - force bit alone enables only link clocks
// R7 - bit 0 clear keeps forced serializers off
// R8 - bit 0 set powers forced lane serializers
// R9 - software writes only while link disabled
// R10 - forced lanes use link mode and test
// R11 - force never overrides link enable or power-down
// R12 - serializer n needs lanes 0..n-1 enabled
// R13 - lane enable is mode OR force, gated
module extra_lane_ctrl #(
  parameter int LANES = xl_pkg::LANES,
  parameter int MODE_W = xl_pkg::MODE_W,
  parameter int TEST_W = xl_pkg::TEST_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [xl_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic [1:0] avs_response,
  output logic avs_waitrequest,
  input wire logic [LANES-1:0] mode_lanes_a,
  input wire logic [LANES-1:0] mode_lanes_b,
  input wire logic [MODE_W-1:0] link_mode_select,
  input wire logic [TEST_W-1:0] link_test_pattern_select,
  output logic serial_link_master_enable,
  output logic [1:0] channel_power_down_control,
  output logic [LANES-1:0] lane_clk_en_a,
  output logic [LANES-1:0] lane_ser_clk_a,
  output logic [LANES-1:0] lane_clk_en_b,
  output logic [LANES-1:0] lane_ser_clk_b,
  output logic [MODE_W-1:0] lane_mode_q,
  output logic [TEST_W-1:0] lane_test_q
);
  xl_pkg::bus_state_t state_q;
  xl_pkg::bus_state_t state_d;
  logic [7:0] link_a_extra_lane_control;
  logic [7:0] link_b_extra_lane_control;
  logic [7:0] ctrl_q;
  logic [1:0] fault_q;
  logic [1:0] fault_d;
  logic [31:0] rdata_d;
  logic [1:0] resp_d;
  logic req;
  logic fire;
  logic wr_fire;
  logic lo_byte;
  logic hit_ctrl;
  logic hit_a;
  logic hit_b;
  logic hit_stat_a;
  logic hit_stat_b;
  logic hit_fault;
  logic mapped;
  logic we_a;
  logic we_b;
  logic we_ctrl;
  logic link_a_on;
  logic link_b_on;
  logic link_a_forced_serializer_on;
  logic link_b_forced_serializer_on;
  logic [LANES-1:0] force_a;
  logic [LANES-1:0] force_b;

  // address decode; each register owns one aligned 32-bit word
  always_comb begin
    hit_ctrl = avs_address == {xl_pkg::IDX_CTRL, 2'h0};
    hit_a = avs_address == {xl_pkg::IDX_LINK_A, 2'h0}; // R1
    hit_b = avs_address == {xl_pkg::IDX_LINK_B, 2'h0}; // R2
    hit_stat_a = avs_address == {xl_pkg::IDX_STAT_A, 2'h0};
    hit_stat_b = avs_address == {xl_pkg::IDX_STAT_B, 2'h0};
    hit_fault = avs_address == {xl_pkg::IDX_FAULT, 2'h0};
    mapped = hit_ctrl | hit_a | hit_b | hit_stat_a | hit_stat_b | hit_fault;
  end

  // one wait state: the first cycle of a request loads the answer,
  // the second drops waitrequest so the master samples it
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & (state_q == xl_pkg::BUS_IDLE);
  assign fire = req & (state_q == xl_pkg::BUS_ACK);
  assign wr_fire = fire & avs_write;
  assign lo_byte = avs_byteenable[0];

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      xl_pkg::BUS_IDLE: begin
        if (req) begin
          state_d = xl_pkg::BUS_ACK;
        end
      end
      xl_pkg::BUS_ACK: begin
        state_d = xl_pkg::BUS_IDLE;
      end
      default: begin
        state_d = xl_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= xl_pkg::BUS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // reconfiguring lanes under a running link would glitch the lane clocks,
  // so lane writes are dropped while the link is enabled and flagged
  always_comb begin
    we_ctrl = wr_fire & lo_byte & hit_ctrl;
    we_a = wr_fire & lo_byte & hit_a & ~serial_link_master_enable; // R9
    we_b = wr_fire & lo_byte & hit_b & ~serial_link_master_enable; // R9
  end

  byte_reg #(
    .RESET(xl_pkg::RST_EXTRA) // R1
  ) u_link_a_reg (
    .clk(clk),
    .nrst(nrst),
    .we(we_a),
    .wdata(avs_writedata[7:0]),
    .value_q(link_a_extra_lane_control)
  );

  byte_reg #(
    .RESET(xl_pkg::RST_EXTRA) // R2
  ) u_link_b_reg (
    .clk(clk),
    .nrst(nrst),
    .we(we_b),
    .wdata(avs_writedata[7:0]),
    .value_q(link_b_extra_lane_control)
  );

  byte_reg #(
    .RESET(xl_pkg::RST_CTRL)
  ) u_ctrl_reg (
    .clk(clk),
    .nrst(nrst),
    .we(we_ctrl),
    .wdata(avs_writedata[7:0]),
    .value_q(ctrl_q)
  );

  assign serial_link_master_enable = ctrl_q[xl_pkg::CTRL_EN_BIT];
  assign channel_power_down_control = {
    ctrl_q[xl_pkg::CTRL_PD_B_BIT],
    ctrl_q[xl_pkg::CTRL_PD_A_BIT]
  };

  // blocked-write flags: write one to clear, a new block wins the clear
  always_comb begin
    fault_d = fault_q;
    if (wr_fire && lo_byte && hit_fault) begin
      fault_d = fault_q & ~avs_writedata[1:0];
    end
    if (wr_fire && lo_byte && serial_link_master_enable) begin
      if (hit_a) begin
        fault_d[xl_pkg::FAULT_A_BIT] = 1'b1; // R9
      end
      if (hit_b) begin
        fault_d[xl_pkg::FAULT_B_BIT] = 1'b1; // R9
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fault_q <= xl_pkg::RST_FAULT;
    end else begin
      fault_q <= fault_d;
    end
  end

  // lane gating per link
  always_comb begin
    link_a_on = serial_link_master_enable & ~channel_power_down_control[0]; // R11
    link_b_on = serial_link_master_enable & ~channel_power_down_control[1]; // R11
    link_a_forced_serializer_on = link_a_extra_lane_control[xl_pkg::SER_BIT];
    link_b_forced_serializer_on = link_b_extra_lane_control[xl_pkg::SER_BIT];
    // lane 0 is never forced; it belongs to every mode
    force_a = {link_a_extra_lane_control[LANES-1:xl_pkg::LANE_LSB], 1'b0}; // R3
    force_b = {link_b_extra_lane_control[LANES-1:xl_pkg::LANE_LSB], 1'b0}; // R4
  end

  lane_gate #(
    .LANES(LANES)
  ) u_gate_a (
    .clk(clk),
    .nrst(nrst),
    .link_on(link_a_on),
    .mode_lanes(mode_lanes_a),
    .force_lanes(force_a),
    .ser_force(link_a_forced_serializer_on),
    .clk_en_q(lane_clk_en_a),
    .ser_clk_q(lane_ser_clk_a)
  );

  lane_gate #(
    .LANES(LANES)
  ) u_gate_b (
    .clk(clk),
    .nrst(nrst),
    .link_on(link_b_on),
    .mode_lanes(mode_lanes_b),
    .force_lanes(force_b),
    .ser_force(link_b_forced_serializer_on),
    .clk_en_q(lane_clk_en_b),
    .ser_clk_q(lane_ser_clk_b)
  );

  // every lane, forced or not, follows the one link-wide rate and format
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lane_mode_q <= '0;
      lane_test_q <= '0;
    end else begin
      lane_mode_q <= link_mode_select; // R10
      lane_test_q <= link_test_pattern_select; // R10
    end
  end

  // read answer is built in the wait cycle and held through the ack cycle
  always_comb begin
    rdata_d = xl_pkg::RST_RDATA;
    resp_d = mapped ? xl_pkg::RESP_OKAY : xl_pkg::RESP_DECERR;
    if (hit_ctrl) begin
      rdata_d[7:0] = ctrl_q;
    end
    if (hit_a) begin
      rdata_d[7:0] = link_a_extra_lane_control;
    end
    if (hit_b) begin
      rdata_d[7:0] = link_b_extra_lane_control;
    end
    if (hit_stat_a) begin
      rdata_d[2*LANES-1:0] = {lane_ser_clk_a, lane_clk_en_a};
    end
    if (hit_stat_b) begin
      rdata_d[2*LANES-1:0] = {lane_ser_clk_b, lane_clk_en_b};
    end
    if (hit_fault) begin
      rdata_d[1:0] = fault_q;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= xl_pkg::RST_RDATA;
      avs_response <= xl_pkg::RESP_OKAY;
    end else if (avs_waitrequest) begin
      avs_readdata <= avs_read ? rdata_d : xl_pkg::RST_RDATA;
      avs_response <= resp_d;
    end
  end

  sequence held_req_s;
    req && avs_waitrequest ##1 req;
  endsequence

  sequence a_write_s;
    wr_fire && hit_a && lo_byte && !serial_link_master_enable;
  endsequence

  sequence b_write_s;
    wr_fire && hit_b && lo_byte && !serial_link_master_enable;
  endsequence

  sequence a_locked_s;
    wr_fire && hit_a && lo_byte && serial_link_master_enable;
  endsequence

  sequence b_locked_s;
    wr_fire && hit_b && lo_byte && serial_link_master_enable;
  endsequence

  bus_ack_a: assert property (@(posedge clk) disable iff (!nrst)
    held_req_s |-> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  a_write_a: assert property (@(posedge clk) disable iff (!nrst) // R3
    a_write_s |=> link_a_extra_lane_control == $past(avs_writedata[7:0]))
    else $error("link A register write lost");
  b_write_a: assert property (@(posedge clk) disable iff (!nrst) // R4
    b_write_s |=> link_b_extra_lane_control == $past(avs_writedata[7:0]))
    else $error("link B register write lost");
  locked_write_a: assert property (@(posedge clk) disable iff (!nrst) // R9
    wr_fire && lo_byte && (hit_a || hit_b) && serial_link_master_enable
      |=> $stable(link_a_extra_lane_control)
        && $stable(link_b_extra_lane_control) && fault_q != 2'h0)
    else $error("lane write accepted while link enabled");
  read_back_a: assert property (@(posedge clk) disable iff (!nrst) // R1
    fire && avs_read && hit_a
      |-> avs_readdata == {24'h0, link_a_extra_lane_control})
    else $error("link A readback wrong");
  unmapped_resp_a: assert property (@(posedge clk) disable iff (!nrst)
    fire && !mapped |-> avs_response == xl_pkg::RESP_DECERR)
    else $error("unmapped access not flagged");
  // the release edge still loads the reset copy, so attempts start after it
  lane_format_a: assert property (@(posedge clk) disable iff (!nrst) // R10
    nrst |=> lane_mode_q == $past(link_mode_select)
      && lane_test_q == $past(link_test_pattern_select))
    else $error("lane format not following link setting");
  force_path_a: assert property (@(posedge clk) disable iff (!nrst) // R13
    link_b_on && link_b_extra_lane_control[1] |=> lane_clk_en_b[1])
    else $error("forced link B lane not enabled");
  // a blocked lane write must leave a flag behind for software to find
  flag_a_set_a: assert property (@(posedge clk) disable iff (!nrst) // R9
    a_locked_s |=> fault_q[xl_pkg::FAULT_A_BIT])
    else $error("blocked link A write not flagged");
  flag_b_set_a: assert property (@(posedge clk) disable iff (!nrst) // R9
    b_locked_s |=> fault_q[xl_pkg::FAULT_B_BIT])
    else $error("blocked link B write not flagged");
  flag_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    wr_fire && lo_byte && hit_fault && avs_writedata[xl_pkg::FAULT_A_BIT]
      |=> !fault_q[xl_pkg::FAULT_A_BIT])
    else $error("link A flag not cleared");
  b_readback_a: assert property (@(posedge clk) disable iff (!nrst) // R2
    fire && avs_read && hit_b
      |-> avs_readdata == {24'h0, link_b_extra_lane_control})
    else $error("link B readback wrong");
  byte_gate_a: assert property (@(posedge clk) disable iff (!nrst)
    wr_fire && !lo_byte
      |=> $stable(link_a_extra_lane_control) && $stable(link_b_extra_lane_control)
        && $stable(ctrl_q))
    else $error("write without low byte enable changed a register");
  ctrl_write_a: assert property (@(posedge clk) disable iff (!nrst)
    wr_fire && lo_byte && hit_ctrl |=> ctrl_q == $past(avs_writedata[7:0]))
    else $error("control register write lost");
  unmapped_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    fire && avs_read && !mapped |-> avs_readdata == '0)
    else $error("unmapped read returned data");
  master_off_a: assert property (@(posedge clk) disable iff (!nrst) // R11
    !serial_link_master_enable
      |=> lane_clk_en_a == '0 && lane_clk_en_b == '0
        && lane_ser_clk_a == '0 && lane_ser_clk_b == '0)
    else $error("lanes active with link master disabled");
  top_lane_a: assert property (@(posedge clk) disable iff (!nrst) // R5
    link_a_on && link_a_extra_lane_control[LANES-1] |=> lane_clk_en_a[LANES-1])
    else $error("forced top link A lane not enabled");
  b_serial_on_a: assert property (@(posedge clk) disable iff (!nrst) // R8
    link_b_on && link_b_forced_serializer_on
      && link_b_extra_lane_control[2:1] == 2'h3 && mode_lanes_b[0]
      |=> lane_ser_clk_b[2])
    else $error("forced link B serializer 2 not enabled");
endmodule

// File: bench/lane_rx_model.sv
`timescale 1ns/100ps
module lane_rx_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [4:0] link_mode_select,
  input wire logic [7:0] lane_clk_en_a,
  input wire logic [7:0] lane_ser_clk_a,
  input wire logic [7:0] lane_clk_en_b,
  input wire logic [7:0] lane_ser_clk_b,
  output logic [7:0] mode_lanes_a,
  output logic [7:0] mode_lanes_b,
  output logic gap_q
);
  logic [8:0] span;
  // the mode alone sets how many lanes are expected: 1, 2, 4 or 8
  assign span = (9'h001 << (4'h1 << link_mode_select[1:0])) - 9'h001;
  assign mode_lanes_a = span[7:0];
  assign mode_lanes_b = span[7:0];
  function automatic logic gap_f(input logic [7:0] c, input logic [7:0] s);
    logic [7:0] low;
    gap_f = 1'b0;
    for (int n = 0; n < 8; n++) begin
      low = (8'h01 << n) - 8'h01;
      if (s[n] && ((c & low) != low)) gap_f = 1'b1;
    end
  endfunction
  // a serializer clocked without its lower lanes would be unusable here
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) gap_q <= 1'b0;
    else if (gap_f(lane_clk_en_a, lane_ser_clk_a) || gap_f(lane_clk_en_b, lane_ser_clk_b))
      gap_q <= 1'b1;
  end
endmodule

// File: bench/serial_link_extra_lane_enable_bench.sv
`timescale 1ns/100ps
module serial_link_extra_lane_enable_bench;
  localparam logic [11:0] CTL = {xl_pkg::IDX_CTRL, 2'b00};
  localparam logic [11:0] LA = {xl_pkg::IDX_LINK_A, 2'b00};
  localparam logic [11:0] LB = {xl_pkg::IDX_LINK_B, 2'b00};
  localparam logic [11:0] FLT = {xl_pkg::IDX_FAULT, 2'b00};
  localparam logic [11:0] STA = {xl_pkg::IDX_STAT_A, 2'b00};
  localparam logic [11:0] STB = {xl_pkg::IDX_STAT_B, 2'b00};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic [1:0] avs_response;
  logic avs_waitrequest;
  logic [7:0] mla, mlb, cea, sca, ceb, scb;
  logic [4:0] mode = 5'h00;
  logic [3:0] test = 4'h0;
  logic [4:0] mode_q;
  logic [3:0] test_q;
  logic men, gap;
  logic [1:0] pd;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [15:0] ea, eb;
  int n_fail = 0;
  int samples_checked = 0;
  logic [7:0] ta[5] = '{8'hFE, 8'hFF, 8'hFF, 8'h0F, 8'hFF};
  logic [7:0] tb[5] = '{8'hAA, 8'h0B, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] tc[5] = '{8'h01, 8'h01, 8'h03, 8'h05, 8'h00};
  logic [4:0] tm[5] = '{5'h00, 5'h11, 5'h0E, 5'h1B, 5'h04};
  logic [7:0] tk[5] = '{8'h01, 8'h03, 8'h0F, 8'hFF, 8'h01};

  initial begin
    forever #25 clk = ~clk;
  end

  extra_lane_ctrl DUT (.clk(clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_response(avs_response), .avs_waitrequest(avs_waitrequest),
    .mode_lanes_a(mla), .mode_lanes_b(mlb), .link_mode_select(mode),
    .link_test_pattern_select(test), .serial_link_master_enable(men),
    .channel_power_down_control(pd), .lane_clk_en_a(cea), .lane_ser_clk_a(sca),
    .lane_clk_en_b(ceb), .lane_ser_clk_b(scb), .lane_mode_q(mode_q), .lane_test_q(test_q));

  lane_rx_model rx (.clk(clk), .nrst(nrst), .link_mode_select(mode),
    .lane_clk_en_a(cea), .lane_ser_clk_a(sca), .lane_clk_en_b(ceb),
    .lane_ser_clk_b(scb), .mode_lanes_a(mla), .mode_lanes_b(mlb), .gap_q(gap));

  task automatic finish_test;
    if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // the request stands until an edge sees waitrequest low; only the watchdog ends a hang
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] be);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, 4'hF);
    chk(rd, exp);
  endtask

  function automatic logic [15:0] exp_f(input logic [7:0] m, input logic [7:0] r,
                                        input logic on);
    logic [7:0] f, c, s;
    logic all;
    f = {r[7:1], 1'b0};
    c = on ? (m | f) : 8'h00;
    s = on ? (m | (r[0] ? f : 8'h00)) : 8'h00;
    all = 1'b1;
    for (int n = 0; n < 8; n++) begin
      s[n] = s[n] & all;
      all = all & c[n];
    end
    exp_f = {c, s};
  endfunction

  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rdc(LA, 32'h0);
    rdc(LB, 32'h0);
    xfer(1'b0, 12'h840, 32'h0, 4'hF);
    chk(rd, 32'h0);
    chk({30'h0, rsp}, {30'h0, xl_pkg::RESP_DECERR});
    for (int i = 0; i < 5; i++) begin
      // extra-lane bits may only change with the link master disabled
      xfer(1'b1, CTL, 32'h0, 4'h1);
      xfer(1'b1, LA, {24'h0, ta[i]}, 4'h1);
      xfer(1'b1, LB, {24'h0, tb[i]}, 4'h1);
      mode <= tm[i];
      test <= tm[i][3:0] ^ 4'h9;
      xfer(1'b1, CTL, {24'h0, tc[i]}, 4'h1);
      repeat (3) @(posedge clk);
      ea = exp_f(tk[i], ta[i], tc[i][0] & ~tc[i][1]);
      eb = exp_f(tk[i], tb[i], tc[i][0] & ~tc[i][2]);
      chk({cea, sca}, ea);
      chk({ceb, scb}, eb);
      chk({men, pd}, {tc[i][0], tc[i][2:1]});
      rdc(STA, {16'h0, ea[7:0], ea[15:8]});
      rdc(STB, {16'h0, eb[7:0], eb[15:8]});
      chk({mode_q, test_q}, {tm[i], tm[i][3:0] ^ 4'h9});
      chk(gap, 1'b0);
      rdc(LA, {24'h0, ta[i]});
      rdc(LB, {24'h0, tb[i]});
    end
    xfer(1'b1, CTL, 32'h1, 4'h1);
    xfer(1'b1, LA, 32'h0, 4'h1);
    rdc(LA, 32'hFF);
    rdc(FLT, 32'h1);
    xfer(1'b1, FLT, 32'h1, 4'h1);
    rdc(FLT, 32'h0);
    xfer(1'b1, LB, 32'h0, 4'h1);
    rdc(LB, 32'hFF);
    rdc(FLT, 32'h2);
    xfer(1'b1, CTL, 32'h0, 4'h1);
    xfer(1'b1, LB, 32'h55, 4'h0);
    rdc(LB, 32'hFF);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rdc(LA, 32'h0);
    rdc(LB, 32'h0);
    chk({cea, sca, ceb, scb}, 32'h0);
    finish_test;
  end

  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    finish_test;
  end
endmodule
